// File: rtl/aat_annunciator.sv
// alarm annunciator and trip outputs: alarm list, three-character display,
// info and acknowledge buttons, fast trip, trip alarm and supervision
// assumes event inputs are synchronous one-cycle pulses and buttons are
// already debounced
`timescale 1ns/1ns
module aat_annunciator #(
  parameter int unsigned HOLD_CYC = aat_pkg::HOLD_CYC,
  parameter int unsigned DEPTH = aat_pkg::LIST_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic err_valid_i,
  input wire aat_pkg::aat_entry_t err_entry_i,
  input wire logic [(2**aat_pkg::CODE_W)-1:0] err_active_i,
  input wire logic trip_detect_i,
  input wire logic trip_active_i,
  input wire logic [aat_pkg::MOD_W-1:0] trip_module_i,
  input wire logic [aat_pkg::SENS_W-1:0] trip_sensor_i,
  input wire logic info_btn_i,
  input wire logic ack_btn_i,
  output aat_pkg::aat_disp_t disp_o,
  output logic [aat_pkg::FAST_TRIPS-1:0] fast_trip_o,
  output logic trip_alarm_o,
  output logic supervision_contact_o,
  output logic overflow_o,
  output logic [$clog2(DEPTH+1)-1:0] alarm_count_o
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);
  localparam int unsigned EW = $bits(aat_pkg::aat_entry_t);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  localparam logic [CW-1:0] ONE = CW'(1);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // letter with dot, then two decimal digits of num
  function automatic aat_pkg::aat_disp_t show(input logic [6:0] glyph,
                                              input logic [6:0] num);
    logic [6:0] n;
    n = num % aat_pkg::DEC_WRAP;
    show.left = '{glyph: glyph, dot: 1'b1};
    show.mid = '{glyph: aat_pkg::GL_ZERO + n / aat_pkg::DEC_BASE,
                 dot: 1'b0};
    show.right = '{glyph: aat_pkg::GL_ZERO + n % aat_pkg::DEC_BASE,
                   dot: 1'b0};
  endfunction

  // ------------------------------------------------------------------
  // buttons
  // ------------------------------------------------------------------
  logic info_tick;
  logic ack_long;
  logic ack_short_rel;
  logic ack_long_rel;

  aat_button #(.HOLD_CYC(HOLD_CYC)) u_info_btn (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .btn_i(info_btn_i),
    .tick_o(info_tick),
    .long_o(),
    .short_rel_o(),
    .long_rel_o()
  );

  aat_button #(.HOLD_CYC(HOLD_CYC)) u_ack_btn (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .btn_i(ack_btn_i),
    .tick_o(),
    .long_o(ack_long),
    .short_rel_o(ack_short_rel),
    .long_rel_o(ack_long_rel)
  );

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [AW-1:0] head, next_head, tail, next_tail;
  logic [CW-1:0] count, next_count, remain, next_remain;
  aat_pkg::aat_sweep_t sweep, next_sweep;
  aat_pkg::aat_entry_t hold, next_hold, head_entry;
  logic hold_valid, next_hold_valid;
  logic overflow, next_overflow;
  logic trip_pend, next_trip_pend;
  logic [aat_pkg::MOD_W-1:0] trip_mod, next_trip_mod;
  logic [aat_pkg::SENS_W-1:0] trip_sens, next_trip_sens;
  logic info_phase, next_info_phase;
  aat_pkg::aat_disp_t next_disp;
  logic next_sup;
  logic wr_en, push, pop, can_drain, ovf_set;
  logic [AW-1:0] wr_addr;
  aat_pkg::aat_entry_t wr_data;
  logic [EW-1:0] rd_raw;

  aat_list_mem #(.WIDTH(EW), .DEPTH(DEPTH), .AW(AW)) u_list (
    .clk_i(clk_i),
    .wr_en_i(wr_en),
    .wr_addr_i(wr_addr),
    .wr_data_i(wr_data),
    .rd_addr_i(head),
    .rd_data_o(rd_raw)
  );

  assign head_entry = aat_pkg::aat_entry_t'(rd_raw);

  // ------------------------------------------------------------------
  // list, trip and acknowledge
  // ------------------------------------------------------------------
  always_comb
  begin
    next_head = head;
    next_tail = tail;
    next_remain = remain;
    next_sweep = sweep;
    next_hold = hold;
    next_hold_valid = hold_valid;
    next_overflow = overflow;
    next_trip_pend = trip_pend;
    next_trip_mod = trip_mod;
    next_trip_sens = trip_sens;
    wr_en = 1'b0;
    wr_addr = tail;
    wr_data = hold;
    push = 1'b0;
    pop = 1'b0;
    ovf_set = 1'b0;
    // the write port is busy only in a sweep decide cycle
    can_drain = hold_valid && (sweep != aat_pkg::SW_DECIDE);
    if (can_drain)
    begin
      next_hold_valid = 1'b0;
      if (count < FULL)
      begin
        wr_en = 1'b1;
        push = 1'b1;
        next_tail = ptr_inc(tail);
      end
      else
      begin
        ovf_set = 1'b1;
      end
    end
    if (err_valid_i)
    begin
      if (hold_valid && !can_drain)
      begin
        ovf_set = 1'b1;
      end
      else
      begin
        next_hold = err_entry_i;
        next_hold_valid = 1'b1;
      end
    end
    unique case (sweep)
      aat_pkg::SW_IDLE:
      begin
        if (ack_short_rel)
        begin
          // trip is the displayed alarm while pending
          if (trip_pend)
          begin
            next_trip_pend = trip_active_i;
          end
          else if (count != '0)
          begin
            pop = !err_active_i[head_entry.code];
          end
          else if (!hold_valid)
          begin
            next_overflow = 1'b0;
          end
        end
        else if (ack_long_rel)
        begin
          next_trip_pend = trip_pend && trip_active_i;
          if (count != '0)
          begin
            next_sweep = aat_pkg::SW_WAIT;
            next_remain = count;
          end
          else if (!hold_valid && !(trip_pend && trip_active_i))
          begin
            next_overflow = 1'b0;
          end
        end
      end
      aat_pkg::SW_WAIT:
      begin
        next_sweep = aat_pkg::SW_DECIDE;
      end
      aat_pkg::SW_DECIDE:
      begin
        // still-active entries rotate to the tail, keeping their order
        next_head = ptr_inc(head);
        if (err_active_i[head_entry.code])
        begin
          wr_en = 1'b1;
          wr_data = head_entry;
          next_tail = ptr_inc(tail);
        end
        else
        begin
          pop = 1'b1;
        end
        next_remain = remain - ONE;
        next_sweep = (remain == ONE) ? aat_pkg::SW_IDLE : aat_pkg::SW_WAIT;
        // overflow goes last, only once the list has drained
        if (remain == ONE && count == ONE && pop && !trip_pend && !hold_valid)
        begin
          next_overflow = 1'b0;
        end
      end
    endcase
    if (pop && sweep == aat_pkg::SW_IDLE)
    begin
      next_head = ptr_inc(head);
    end
    next_count = count + CW'(push) - CW'(pop);
    if (ovf_set)
    begin
      next_overflow = 1'b1;
    end
    // set wins over a same-cycle acknowledge; only the first detection sets module and sensor
    if (trip_detect_i)
    begin
      next_trip_pend = 1'b1;
      if (!trip_pend)
      begin
        next_trip_mod = trip_module_i;
        next_trip_sens = trip_sensor_i;
      end
    end
    next_sup = !(next_count != '0 || next_hold_valid || next_overflow);
  end

  // ------------------------------------------------------------------
  // display
  // ------------------------------------------------------------------
  always_comb
  begin
    next_info_phase = info_btn_i && (info_phase ^ info_tick);
    next_disp = '{left: '{glyph: aat_pkg::GL_BLANK, dot: 1'b0},
                  mid: '{glyph: aat_pkg::GL_BLANK, dot: 1'b0},
                  right: '{glyph: aat_pkg::GL_BLANK, dot: 1'b0}};
    if (ack_long)
    begin
      next_disp = '{left: '{glyph: aat_pkg::GL_A, dot: 1'b0},
                    mid: '{glyph: aat_pkg::GL_C, dot: 1'b0},
                    right: '{glyph: aat_pkg::GL_K, dot: 1'b0}};
    end
    else if (trip_pend)
    begin
      if (!info_btn_i)
      begin
        next_disp = show(aat_pkg::GL_T, aat_pkg::CODE_TRIP);
      end
      else if (!info_phase)
      begin
        next_disp = show(aat_pkg::GL_M, 7'(trip_mod));
      end
      else
      begin
        next_disp = show(aat_pkg::GL_S, trip_sens);
      end
    end
    else if (count != '0)
    begin
      if (!info_btn_i)
      begin
        next_disp = show(aat_pkg::GL_E, head_entry.code);
      end
      else if (!info_phase)
      begin
        next_disp = show(aat_pkg::GL_M, 7'(head_entry.module_addr));
      end
      else
      begin
        next_disp = show(aat_pkg::GL_S, head_entry.sensor);
      end
    end
    else if (overflow)
    begin
      next_disp = show(aat_pkg::GL_E, aat_pkg::CODE_OVERFLOW);
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      head <= '0;
      tail <= '0;
      count <= '0;
      remain <= '0;
      sweep <= aat_pkg::SW_IDLE;
      hold <= '0;
      hold_valid <= 1'b0;
      overflow <= 1'b0;
      trip_pend <= 1'b0;
      trip_mod <= '0;
      trip_sens <= '0;
      info_phase <= 1'b0;
      disp_o <= '{left: '{glyph: aat_pkg::GL_BLANK, dot: 1'b0},
                  mid: '{glyph: aat_pkg::GL_BLANK, dot: 1'b0},
                  right: '{glyph: aat_pkg::GL_BLANK, dot: 1'b0}};
      fast_trip_o <= '0;
      trip_alarm_o <= 1'b0;
      supervision_contact_o <= 1'b1;
    end
    else
    begin
      head <= next_head;
      tail <= next_tail;
      count <= next_count;
      remain <= next_remain;
      sweep <= next_sweep;
      hold <= next_hold;
      hold_valid <= next_hold_valid;
      overflow <= next_overflow;
      trip_pend <= next_trip_pend;
      trip_mod <= next_trip_mod;
      trip_sens <= next_trip_sens;
      info_phase <= next_info_phase;
      disp_o <= next_disp;
      fast_trip_o <= {aat_pkg::FAST_TRIPS{next_trip_pend}};
      trip_alarm_o <= next_trip_pend;
      supervision_contact_o <= next_sup;
    end
  end

  assign overflow_o = overflow;
  assign alarm_count_o = count;

endmodule

// File: rtl/aat_button.sv
// press timer for one operator button, input already clean and synchronous
// tick pulses once per hold period while held; long marks a long hold
`timescale 1ns/1ns
module aat_button #(
  parameter int unsigned HOLD_CYC = aat_pkg::HOLD_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic btn_i,
  output logic tick_o,
  output logic long_o,
  output logic short_rel_o,
  output logic long_rel_o
);

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic prev;
  logic long_held;
  logic next_long_held;

  // ------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------
  always_comb
  begin
    tick_o = btn_i && (cnt == HOLD_CYC - 1);
    next_cnt = 32'h0;
    if (btn_i && !tick_o)
    begin
      next_cnt = cnt + 32'h1;
    end
    next_long_held = btn_i && (long_held || tick_o);
    long_o = long_held;
    short_rel_o = prev && !btn_i && !long_held;
    long_rel_o = prev && !btn_i && long_held;
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt <= 32'h0;
      prev <= 1'b0;
      long_held <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      prev <= btn_i;
      long_held <= next_long_held;
    end
  end

endmodule

// File: rtl/aat_list_mem.sv
// storage for the pending alarm list: one write port, one read port
// read data come from a register one clock after the address
`timescale 1ns/1ns
module aat_list_mem #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 100,
  parameter int unsigned AW = 7
) (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ------------------------------------------------------------------
  // array has no reset; the list counters decide what is valid
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end

endmodule

// File: rtl/aat_pkg.sv
// shared constants and types of the alarm annunciator and trip block
// assumes one 250 MHz clock and synchronous, active-high reset
package aat_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned HOLD_SEC = 2;
  localparam int unsigned HOLD_CYC = HOLD_SEC * CLK_HZ;

  // ----------------------------------------------------------------
  // alarm list
  // ----------------------------------------------------------------
  localparam int unsigned LIST_DEPTH = 100;
  localparam int unsigned CODE_W = 7;
  localparam int unsigned MOD_W = 5;
  localparam int unsigned SENS_W = 7;
  localparam int unsigned FAST_TRIPS = 3;
  localparam logic [CODE_W-1:0] CODE_TRIP = 7'h0D;
  localparam logic [CODE_W-1:0] CODE_OVERFLOW = 7'h35;

  // ----------------------------------------------------------------
  // display glyphs, ascii coded, dot carried separately
  // ----------------------------------------------------------------
  localparam logic [6:0] GL_BLANK = 7'h20;
  localparam logic [6:0] GL_ZERO = 7'h30;
  localparam logic [6:0] GL_A = 7'h41;
  localparam logic [6:0] GL_C = 7'h43;
  localparam logic [6:0] GL_E = 7'h45;
  localparam logic [6:0] GL_K = 7'h4B;
  localparam logic [6:0] GL_M = 7'h4D;
  localparam logic [6:0] GL_S = 7'h53;
  localparam logic [6:0] GL_T = 7'h54;
  localparam logic [6:0] DEC_BASE = 7'h0A;
  localparam logic [6:0] DEC_WRAP = 7'h64;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [MOD_W-1:0] module_addr;
    logic [SENS_W-1:0] sensor;
  } aat_entry_t;

  typedef struct packed {
    logic [6:0] glyph;
    logic dot;
  } aat_char_t;

  typedef struct packed {
    aat_char_t left;
    aat_char_t mid;
    aat_char_t right;
  } aat_disp_t;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_WAIT,
    SW_DECIDE
  } aat_sweep_t;

endpackage

// File: tb/aat_annunciator_props.sv
// assertions on the annunciator ports: trips, supervision, display
// assumes binding to aat_annunciator, one clock, synchronous reset
`timescale 1ns/1ns
module aat_annunciator_chk #(
  parameter int unsigned HOLD_CYC = 20,
  parameter int unsigned DEPTH = 100
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic err_valid_i,
  input wire aat_pkg::aat_entry_t err_entry_i,
  input wire logic [(2**aat_pkg::CODE_W)-1:0] err_active_i,
  input wire logic trip_detect_i,
  input wire logic trip_active_i,
  input wire logic [aat_pkg::MOD_W-1:0] trip_module_i,
  input wire logic [aat_pkg::SENS_W-1:0] trip_sensor_i,
  input wire logic info_btn_i,
  input wire logic ack_btn_i,
  input wire aat_pkg::aat_disp_t disp_o,
  input wire logic [aat_pkg::FAST_TRIPS-1:0] fast_trip_o,
  input wire logic trip_alarm_o,
  input wire logic supervision_contact_o,
  input wire logic overflow_o,
  input wire logic [$clog2(DEPTH+1)-1:0] alarm_count_o
);
  // ----------------------------------------------------------------
  // acknowledge hold counter
  // ----------------------------------------------------------------
  int unsigned ack_cnt;
  int unsigned next_ack_cnt;
  always_comb
  begin
    next_ack_cnt = ack_btn_i ? ack_cnt + 1 : 0;
  end
  always_ff @(posedge clk_i)
  begin
    ack_cnt <= rst_i ? 0 : next_ack_cnt;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  trip_fast_a: assert property (trip_detect_i
    |=> fast_trip_o == 3'h7 && trip_alarm_o)
    else $error("trip outputs not closed after detect");
  trips_together_a: assert property (
    fast_trip_o == 3'h0 || fast_trip_o == 3'h7)
    else $error("fast trip outputs disagree");
  trip_hold_a: assert property (trip_alarm_o && trip_active_i
    |=> trip_alarm_o && fast_trip_o == 3'h7)
    else $error("trip released while source active");
  sup_open_a: assert property (err_valid_i
    |=> !supervision_contact_o)
    else $error("supervision not opened on error");
  // an error may wait two cycles in the hold register before the list, so look two cycles back
  sup_closed_a: assert property (
    alarm_count_o == 0 && $past(alarm_count_o) == 0 && !overflow_o
    && !$past(overflow_o) && !$past(err_valid_i) && !$past(err_valid_i, 2)
    |-> supervision_contact_o)
    else $error("supervision open while healthy");
  ovf_set_a: assert property (err_valid_i && alarm_count_o == DEPTH
    && !$past(ack_btn_i) |-> ##[1:3] overflow_o)
    else $error("overflow not raised on full list");
  count_up_a: assert property (err_valid_i && !$past(err_valid_i)
    && !ack_btn_i && !$past(ack_btn_i) && alarm_count_o < DEPTH - 1
    ##1 !err_valid_i && !ack_btn_i
    |=> alarm_count_o == $past(alarm_count_o, 2) + 1)
    else $error("error not logged in list");
  blank_idle_a: assert property (
    alarm_count_o == 0 && $past(alarm_count_o) == 0
    && $past(alarm_count_o, 2) == 0 && !overflow_o && !$past(overflow_o)
    && !trip_alarm_o && !$past(trip_alarm_o) && !ack_btn_i
    && !$past(ack_btn_i) && !$past(ack_btn_i, 2) && !$past(err_valid_i)
    && !$past(err_valid_i, 2)
    |-> disp_o == 24'h404040)
    else $error("display not blank with nothing pending");
  trip_disp_a: assert property (trip_alarm_o && $past(trip_alarm_o)
    && !ack_btn_i && !$past(ack_btn_i) && !$past(ack_btn_i, 2)
    && !info_btn_i && !$past(info_btn_i)
    |-> disp_o == 24'hA96266)
    else $error("trip code not shown");
  ack_text_a: assert property (ack_btn_i && ack_cnt > HOLD_CYC + 2
    |-> disp_o == 24'h828696)
    else $error("long acknowledge text not shown");
endmodule
bind aat_annunciator aat_annunciator_chk #(
  .HOLD_CYC(HOLD_CYC),
  .DEPTH(DEPTH)
) chk_i (.*);

// File: tb/aat_switchgear.sv
// switchgear model: three trip coils and the trip indication lamp
// assumes contact outputs high means closed
`timescale 1ns/1ns
module aat_switchgear (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] fast_trip_i,
  input wire logic trip_alarm_i,
  output logic breaker_open_o,
  output logic skew_o
);
  // a breaker stays open once tripped, like the real pole
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      breaker_open_o <= 1'h0;
      skew_o <= 1'h0;
    end
    else
    begin
      breaker_open_o <= breaker_open_o | (&fast_trip_i);
      if ((|fast_trip_i != &fast_trip_i) || (trip_alarm_i != |fast_trip_i))
        skew_o <= 1'h1;
    end
  end
endmodule

// File: tb/testbench.sv
// self-checking bench for the annunciator with a switchgear model
// assumes short hold period and a four-entry list to keep the run small
`timescale 1ns/1ns
module testbench;
  localparam int unsigned HC = 20;
  localparam int unsigned DP = 4;
  logic clk_i, rst_i, err_valid_i, trip_detect_i, trip_active_i;
  logic info_btn_i, ack_btn_i, trip_alarm_o, supervision_contact_o;
  logic overflow_o, breaker_open, skew;
  aat_pkg::aat_entry_t err_entry_i;
  logic [127:0] err_active_i;
  logic [4:0] trip_module_i;
  logic [6:0] trip_sensor_i;
  aat_pkg::aat_disp_t disp_o;
  logic [2:0] fast_trip_o;
  logic [2:0] alarm_count_o;
  int err_count, n_checks;
  aat_annunciator #(.HOLD_CYC(HC), .DEPTH(DP)) aat_annunciator_i (.*);
  aat_switchgear aat_switchgear_i (.clk_i(clk_i), .rst_i(rst_i),
    .fast_trip_i(fast_trip_o), .trip_alarm_i(trip_alarm_o),
    .breaker_open_o(breaker_open), .skew_o(skew));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [23:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  function automatic logic [23:0] dsp(input logic [6:0] l, input int n);
    return {l, 1'h1, 7'h30 + 7'(n / 10), 1'h0, 7'h30 + 7'(n % 10), 1'h0};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic send_err(input logic [6:0] c, input logic [4:0] m,
                          input logic [6:0] s);
    @(posedge clk_i);
    err_valid_i <= 1'h1;
    err_entry_i <= {c, m, s};
    @(posedge clk_i);
    err_valid_i <= 1'h0;
  endtask
  // sweep takes two cycles an entry, so the tail covers a full list
  task automatic ack(input int n);
    @(posedge clk_i);
    ack_btn_i <= 1'h1;
    tick(n);
    ack_btn_i <= 1'h0;
    tick(12);
  endtask
  task automatic info(input logic [23:0] m, s, back);
    @(posedge clk_i);
    info_btn_i <= 1'h1;
    tick(4);
    check("module", disp_o, m);
    tick(HC);
    check("sensor", disp_o, s);
    info_btn_i <= 1'h0;
    tick(4);
    check("back", disp_o, back);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'h0;
    forever #2 clk_i = ~clk_i;
  end
  initial
  begin
    #200000;
    err_count++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    {rst_i, err_valid_i, trip_detect_i, trip_active_i} = 4'hF;
    {err_valid_i, trip_detect_i, trip_active_i} = 3'h0;
    {info_btn_i, ack_btn_i, err_entry_i} = '0;
    {err_active_i, trip_module_i, trip_sensor_i} = '0;
    tick(16);
    rst_i <= 1'h0;
    tick(3);
    check("blank", disp_o, 24'h404040);
    check("sup", 24'(supervision_contact_o), 24'h1);
    err_active_i[7'h12] <= 1'h1;
    send_err(7'h12, 5'h03, 7'h05);
    send_err(7'h2F, 5'h07, 7'h09);
    tick(4);
    check("count", 24'(alarm_count_o), 24'h2);
    check("sup", 24'(supervision_contact_o), 24'h0);
    check("oldest", disp_o, dsp(aat_pkg::GL_E, 18));
    info(dsp(aat_pkg::GL_M, 3), dsp(aat_pkg::GL_S, 5),
         dsp(aat_pkg::GL_E, 18));
    ack(1);
    check("kept", 24'(alarm_count_o), 24'h2);
    err_active_i[7'h12] <= 1'h0;
    ack(1);
    check("popped", 24'(alarm_count_o), 24'h1);
    check("next", disp_o, dsp(aat_pkg::GL_E, 47));
    @(posedge clk_i);
    {trip_detect_i, trip_active_i} <= 2'h3;
    trip_module_i <= 5'h04;
    trip_sensor_i <= 7'h06;
    @(posedge clk_i);
    trip_detect_i <= 1'h0;
    #1 check("fast", 24'(fast_trip_o), 24'h7);
    check("alarm", 24'(trip_alarm_o), 24'h1);
    tick(3);
    check("trip", disp_o, dsp(aat_pkg::GL_T, 13));
    check("breaker", 24'({breaker_open, skew}), 24'h2);
    info(dsp(aat_pkg::GL_M, 4), dsp(aat_pkg::GL_S, 6),
         dsp(aat_pkg::GL_T, 13));
    ack(1);
    check("trip kept", 24'(trip_alarm_o), 24'h1);
    trip_active_i <= 1'h0;
    ack(1);
    check("trip gone", 24'({trip_alarm_o, fast_trip_o}), 24'h0);
    check("err shown", disp_o, dsp(aat_pkg::GL_E, 47));
    send_err(7'h30, 5'h01, 7'h02);
    @(posedge clk_i);
    ack_btn_i <= 1'h1;
    tick(HC + 4);
    check("ack text", disp_o, 24'h828696);
    ack_btn_i <= 1'h0;
    tick(12);
    check("all", 24'(alarm_count_o), 24'h0);
    check("blank", disp_o, 24'h404040);
    check("sup", 24'(supervision_contact_o), 24'h1);
    err_active_i[7'h01] <= 1'h1;
    for (int i = 1; i <= 5; i++)
      send_err(7'(i), 5'(i), 7'(i));
    tick(4);
    check("full", 24'({overflow_o, alarm_count_o}), 24'hC);
    ack(HC + 4);
    check("active kept", 24'({overflow_o, alarm_count_o}), 24'h9);
    err_active_i[7'h01] <= 1'h0;
    ack(1);
    check("ovf only", 24'({overflow_o, alarm_count_o}), 24'h8);
    check("ovf code", disp_o, dsp(aat_pkg::GL_E, 53));
    check("sup", 24'(supervision_contact_o), 24'h0);
    ack(1);
    check("ovf clear", 24'(overflow_o), 24'h0);
    check("blank", disp_o, 24'h404040);
    complete_run();
  end
endmodule
